// *** src/rgp_pkg.sv ***
// Behaviour
// - with the secondary-port select set, the pin 1/2 and pin 3 registers read and write the secondary pin set.
// - a pin drives its local output value only when GPIO is enabled, direction is output and remote control is off.
// - with remote control set, the pin is forced to output and driven with the value received over the link.
// - with remote control clear, the remote value is ignored and local configuration is followed.
// - the direction and enable bits form a code: 00 functional output, 10 tri-state, 01 GPIO output, 11 GPIO input.
// - the pin 1/2 register sits at 0x1E, is read/write and resets to zero.
// - the pin 3 register sits at 0x1F, resets to zero, and its upper four bits are reserved.
// - the pin 5/6 register sits at 0x20 and resets to zero.
package rgp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFS_PINS_ONE_TWO = 8'h1E;
	localparam logic [7:0] OFS_PIN_THREE = 8'h1F;
	localparam logic [7:0] OFS_PINS_FIVE_SIX = 8'h20;
	localparam logic [7:0] OFS_PORT_SELECT = 8'h30;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam int BIT_VALUE = 3;
	localparam int BIT_REMOTE = 2;
	localparam int BIT_DIR = 1;
	localparam int BIT_EN = 0;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		RGP_MODE_FUNC = 2'b00,
		RGP_MODE_GPIO_OUT = 2'b01,
		RGP_MODE_TRISTATE = 2'b10,
		RGP_MODE_GPIO_IN = 2'b11
	} rgp_mode_t;
endpackage : rgp_pkg

// *** src/rgp_pin_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module rgp_pin_ctrl
	import rgp_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// configuration nibble
	input wire logic [3:0] cfg_i,
	// remote value, already on this clock
	input wire logic remote_value_i,
	// functional output from the core
	input wire logic func_value_i,
	// pad
	input wire logic pad_i,
	output logic pad_o,
	output logic pad_oe_o,
	output logic pad_level_o
);
	rgp_mode_t mode;
	logic [SYNC_STAGES-1:0] sync;
	logic [SYNC_STAGES-1:0] next_sync;
	logic next_pad_o;
	logic next_pad_oe_o;

	// ************************
	// pad control
	// ************************
	always_comb begin
		mode = rgp_mode_t'({cfg_i[BIT_DIR], cfg_i[BIT_EN]});
		next_sync = {sync[SYNC_STAGES-2:0], pad_i};
		next_pad_o = 1'b0;
		next_pad_oe_o = 1'b0;
		if (cfg_i[BIT_REMOTE]) begin
			next_pad_oe_o = 1'b1;
			next_pad_o = remote_value_i;
		end else begin
			// remote value unused here
			case (mode)
				RGP_MODE_FUNC: begin
					next_pad_oe_o = 1'b1;
					next_pad_o = func_value_i;
				end
				RGP_MODE_GPIO_OUT: begin
					next_pad_oe_o = 1'b1;
					next_pad_o = cfg_i[BIT_VALUE];
				end
				RGP_MODE_TRISTATE: next_pad_oe_o = 1'b0;
				RGP_MODE_GPIO_IN: next_pad_oe_o = 1'b0;
				default: next_pad_oe_o = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync <= '0;
			pad_o <= 1'b0;
			pad_oe_o <= 1'b0;
		end else begin
			sync <= next_sync;
			pad_o <= next_pad_o;
			pad_oe_o <= next_pad_oe_o;
		end
	end

	assign pad_level_o = sync[SYNC_STAGES-1];
endmodule : rgp_pin_ctrl
`default_nettype wire

// *** src/rgp_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module rgp_top
	import rgp_pkg::*;
#(
	parameter int NPINS = 5
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// register port
	input wire logic [rgp_pkg::ADDR_W-1:0] addr_i,
	input wire logic [rgp_pkg::DATA_W-1:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [rgp_pkg::DATA_W-1:0] rdata_o,
	// remote values from the link, order: pin 1,2,3,5,6
	input wire logic [NPINS-1:0] remote_value_i,
	// core functional outputs, same order
	input wire logic [NPINS-1:0] func_value_i,
	// primary pads, order: pin 1,2,3,5,6
	input wire logic [NPINS-1:0] pad_i,
	output logic [NPINS-1:0] pad_o,
	output logic [NPINS-1:0] pad_oe_o,
	// secondary-port pads: pin 1,2,3
	input wire logic [2:0] sec_pad_i,
	output logic [2:0] sec_pad_o,
	output logic [2:0] sec_pad_oe_o,
	// synchronised pad levels
	output logic [NPINS-1:0] pad_level_o,
	output logic [2:0] sec_pad_level_o
);
	import rgp_pkg::*;

	logic [7:0] pri_one_two, pri_three, sec_one_two, sec_three, five_six;
	logic secondary_port_select;
	logic [7:0] next_pri_one_two, next_pri_three, next_sec_one_two, next_sec_three, next_five_six;
	logic next_secondary_port_select;
	logic [7:0] next_rdata;
	logic [NPINS*4-1:0] pri_cfg;
	logic [11:0] sec_cfg;
	logic [NPINS-1:0] pri_level;
	logic [2:0] sec_level;

	// ************************
	// register file
	// ************************
	function automatic logic [7:0] low_nibble(input logic [7:0] v);
		return {4'h0, v[3:0]};
	endfunction : low_nibble

	always_comb begin
		next_pri_one_two = pri_one_two;
		next_pri_three = pri_three;
		next_sec_one_two = sec_one_two;
		next_sec_three = sec_three;
		next_five_six = five_six;
		next_secondary_port_select = secondary_port_select;
		next_rdata = 8'h00;
		if (write_i) begin
			case (addr_i)
				OFS_PINS_ONE_TWO: begin
					if (secondary_port_select) next_sec_one_two = wdata_i;
					else next_pri_one_two = wdata_i;
				end
				OFS_PIN_THREE: begin
					if (secondary_port_select) next_sec_three = low_nibble(wdata_i);
					else next_pri_three = low_nibble(wdata_i);
				end
				OFS_PINS_FIVE_SIX: next_five_six = wdata_i;
				OFS_PORT_SELECT: next_secondary_port_select = wdata_i[0];
				default: next_rdata = 8'h00;
			endcase
		end
		if (read_i) begin
			case (addr_i)
				OFS_PINS_ONE_TWO: next_rdata = secondary_port_select ? sec_one_two : pri_one_two;
				OFS_PIN_THREE: next_rdata = secondary_port_select ? sec_three : pri_three;
				OFS_PINS_FIVE_SIX: next_rdata = five_six;
				OFS_PORT_SELECT: next_rdata = {7'h00, secondary_port_select};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pri_one_two <= RST_CONFIG;
			pri_three <= RST_CONFIG;
			sec_one_two <= RST_CONFIG;
			sec_three <= RST_CONFIG;
			five_six <= RST_CONFIG;
			secondary_port_select <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			pri_one_two <= next_pri_one_two;
			pri_three <= next_pri_three;
			sec_one_two <= next_sec_one_two;
			sec_three <= next_sec_three;
			five_six <= next_five_six;
			secondary_port_select <= next_secondary_port_select;
			rdata_o <= next_rdata;
		end
	end

	// ************************
	// pin nibbles
	// ************************
	// higher pin in upper nibble
	assign pri_cfg = {five_six[7:4], five_six[3:0], pri_three[3:0], pri_one_two[7:4], pri_one_two[3:0]};
	assign sec_cfg = {sec_three[3:0], sec_one_two[7:4], sec_one_two[3:0]};

	// ************************
	// pad instances
	// ************************
	// remote values feed both pin sets; the link addresses pins by number
	for (genvar i = 0; i < NPINS; i++) begin : g_pri
		rgp_pin_ctrl u_pin (
			.clock_i(clock_i),
			.resetn_i(resetn_i),
			.cfg_i(pri_cfg[i*4 +: 4]),
			.remote_value_i(remote_value_i[i]),
			.func_value_i(func_value_i[i]),
			.pad_i(pad_i[i]),
			.pad_o(pad_o[i]),
			.pad_oe_o(pad_oe_o[i]),
			.pad_level_o(pri_level[i])
		);
	end
	for (genvar j = 0; j < 3; j++) begin : g_sec
		rgp_pin_ctrl u_pin (
			.clock_i(clock_i),
			.resetn_i(resetn_i),
			.cfg_i(sec_cfg[j*4 +: 4]),
			.remote_value_i(remote_value_i[j]),
			.func_value_i(func_value_i[j]),
			.pad_i(sec_pad_i[j]),
			.pad_o(sec_pad_o[j]),
			.pad_oe_o(sec_pad_oe_o[j]),
			.pad_level_o(sec_level[j])
		);
	end

	assign pad_level_o = pri_level;
	assign sec_pad_level_o = sec_level;
endmodule : rgp_top
`default_nettype wire

// *** testbench/rgp_top_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module rgp_checker
	import rgp_pkg::*;
#(parameter int NPINS = 5) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic [NPINS-1:0] remote_value_i,
	input wire logic [NPINS-1:0] func_value_i,
	input wire logic [NPINS-1:0] pad_o,
	input wire logic [NPINS-1:0] pad_oe_o
);
	logic [7:0] sh, next_sh;
	logic live;
	// 0x20 only: port select leaves it alone
	always_comb next_sh = (write_i && addr_i == 8'h20) ? wdata_i : sh;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sh <= 8'h00;
			live <= 1'b0;
		end else begin
			sh <= next_sh;
			live <= 1'b1;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	a_remote_five: assert property (
		live && $past(sh[2]) |-> pad_oe_o[3] && pad_o[3] == $past(remote_value_i[3])) else $error("remote5");
	a_remote_six: assert property (
		live && $past(sh[6]) |-> pad_oe_o[4] && pad_o[4] == $past(remote_value_i[4])) else $error("remote6");
	a_local_value: assert property (
		live && $past(sh[2:0]) == 3'b001 |-> pad_oe_o[3] && pad_o[3] == $past(sh[3])) else $error("local");
	a_remote_ignored: assert property (
		live && $past(sh[6:4]) == 3'b000 |-> pad_oe_o[4] && pad_o[4] == $past(func_value_i[4])) else $error("func");
	a_tristate_off: assert property (live && $past(sh[2:0]) == 3'b010 |-> !pad_oe_o[3]) else $error("tri");
	a_input_off: assert property (live && $past(sh[6:4]) == 3'b011 |-> !pad_oe_o[4]) else $error("in");
	a_reg_readback: assert property (read_i && addr_i == 8'h20 |=> rdata_o == $past(sh)) else $error("rd20");
	a_reserved_zero: assert property (read_i && addr_i == 8'h1F |=> rdata_o[7:4] == 4'h0) else $error("rsv");
	c_remote: cover property (write_i && addr_i == 8'h20 && wdata_i[2]);
	c_select: cover property (write_i && addr_i == 8'h30 && wdata_i[0]);
	c_read: cover property (read_i ##1 rdata_o != 8'h00);
endmodule : rgp_checker
bind rgp_top rgp_checker #(.NPINS(NPINS)) chk_u (.clock_i, .resetn_i, .addr_i, .wdata_i, .write_i, .read_i,
	.rdata_o, .remote_value_i, .func_value_i, .pad_o, .pad_oe_o);
`default_nettype wire

// *** testbench/rgp_remote_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rgp_remote_model (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic slow_i,
	input wire logic [4:0] value_i,
	output logic [4:0] remote_value_o
);
	logic [4:0] held;
	// slow mode: link values land one cycle late
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			held <= 5'h00;
			remote_value_o <= 5'h00;
		end else begin
			held <= value_i;
			remote_value_o <= slow_i ? held : value_i;
		end
	end
endmodule : rgp_remote_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import rgp_pkg::*;
	logic clock_i, resetn_i, write_i, read_i, slow;
	logic [7:0] addr_i, wdata_i, rdata_o, d;
	logic [4:0] rv, fv, pin_i, rem, pad_o, pad_oe_o, lvl;
	logic [2:0] spin_i, sec_pad_o, sec_pad_oe_o, slvl;
	logic [15:0] ex;
	int n_fail = 0;
	int n_checks = 0;
	rgp_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
		.read_i(read_i), .rdata_o(rdata_o), .remote_value_i(rem), .func_value_i(fv), .pad_i(pin_i), .pad_o(pad_o),
		.pad_oe_o(pad_oe_o), .sec_pad_i(spin_i), .sec_pad_o(sec_pad_o), .sec_pad_oe_o(sec_pad_oe_o),
		.pad_level_o(lvl), .sec_pad_level_o(slvl));
	rgp_remote_model rm_u (.clock_i(clock_i), .resetn_i(resetn_i), .slow_i(slow), .value_i(rv), .remote_value_o(rem));
	function automatic logic [15:0] pads(input logic [7:0] c, input logic [4:0] r, input logic [4:0] f);
		logic [15:0] v;
		logic [3:0] n;
		v = 16'h0000;
		for (int k = 0; k < 5; k++) begin
			n = (k == 1 || k == 4) ? c[7:4] : c[3:0];
			v[k] = n[2] || !n[1];
			v[k + 8] = n[2] ? r[k] : (n[1:0] == 2'b00) ? f[k] : (n[1:0] == 2'b01) ? n[3] : 1'b0;
		end
		return v;
	endfunction : pads
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock_i);
		{write_i, addr_i, wdata_i} <= {1'b1, a, v};
		@(posedge clock_i);
		write_i <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_i);
		{read_i, addr_i} <= {1'b1, a};
		@(posedge clock_i);
		read_i <= 1'b0;
		#1 chk("rdata", {a, e}, {a, rdata_o});
	endtask : rc
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		repeat (5000) @(posedge clock_i);
		n_fail++;
		close_out();
	end
	initial begin
		{resetn_i, write_i, read_i, slow, addr_i, wdata_i} = 20'h00000;
		{rv, fv, pin_i, spin_i} = 18'h00000;
		void'($urandom(94));
		repeat (8) @(posedge clock_i);
		resetn_i <= 1'b1;
		rc(8'h1E, 8'h00);
		rc(8'h1F, 8'h00);
		rc(8'h20, 8'h00);
		wr(8'h55, 8'hFF);
		rc(8'h55, 8'h00);
		chk("reset pads", pads(8'h00, rv, fv), {3'h0, pad_oe_o & pad_o, 3'h0, pad_oe_o});
		$display("reset test done");
		// first 16 rounds walk every nibble code on both halves
		for (int i = 0; i < 40; i++) begin
			d = (i < 16) ? {~i[3:0], i[3:0]} : 8'($urandom);
			wr(8'h1E, d);
			wr(8'h1F, d);
			wr(8'h20, d);
			{rv, fv, pin_i, spin_i, slow} <= {18'($urandom), i[0]};
			rc(8'h1E, d);
			rc(8'h1F, {4'h0, d[3:0]});
			rc(8'h20, d);
			chk("pads", pads(d, rv, fv), {3'h0, pad_oe_o & pad_o, 3'h0, pad_oe_o});
			chk("levels", {8'h00, spin_i, pin_i}, {8'h00, slvl, lvl});
		end
		$display("mode test done");
		ex = pads(d, rv, fv);
		wr(8'h30, 8'h01);
		wr(8'h1E, 8'h22);
		wr(8'h1F, 8'h09);
		rc(8'h1E, 8'h22);
		rc(8'h1F, 8'h09);
		chk("sel oe", {8'h00, 3'b100, ex[4:0]}, {8'h00, sec_pad_oe_o, pad_oe_o});
		chk("sel value", {8'h00, 3'b100, ex[12:8]}, {8'h00, sec_pad_oe_o & sec_pad_o, pad_oe_o & pad_o});
		wr(8'h1E, 8'h44);
		rc(8'h30, 8'h01);
		chk("sel remote", {8'h00, 1'b1, rv[1:0], 3'b111}, {8'h00, sec_pad_oe_o & sec_pad_o, sec_pad_oe_o});
		wr(8'h30, 8'h00);
		rc(8'h1E, d);
		rc(8'h1F, {4'h0, d[3:0]});
		chk("pri pads", ex, {3'h0, pad_oe_o & pad_o, 3'h0, pad_oe_o});
		$display("select test done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
